// *** eid_top.sv ***
// Module: five-line external interrupt edge detector with wake-up
`timescale 1ns/1ns
// Contract
// R1: line zero, select bit one: only falling edges request.
// R2: line zero, select bit zero: rising and falling edges request.
// R3: line one, select bit two one: only falling edges request.
// R4: line one, select zero: rising and falling edges request.
// R5: line two requests on falling edges only.
// R6: line three requests on falling edges only.
// R7: line one edges can wake from power-down without clock; here wake needs the sampling clock running.
// R8: lines two and three falling edges wake from power-down without clock; here wake needs the sampling clock running.
// R9: line four edges wake from power-down without clock; here wake needs the sampling clock running.
// R10: line four requests on falling edges only.
// R11: each edge sets a sticky pending flag until acknowledged or cleared.
// R12: with clock running, pins are synchronised and samples compared.
module eid_top
  import eid_pkg::*;
(
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  // Interrupt pins
  input  wire logic                              ext_irq_line_zero,
  input  wire logic                              ext_irq_line_one,
  input  wire logic                              ext_irq_line_two,
  input  wire logic                              ext_irq_line_three,
  input  wire logic                              ext_irq_line_four,
  // Control register image, power-down and flag clearing
  input  wire logic [eid_pkg::CTRL_W-1:0]        timer_irq_control_reg,
  input  wire logic                              power_down,
  input  wire logic [eid_pkg::NUM_LINES-1:0]     irq_ack,
  input  wire logic [eid_pkg::NUM_LINES-1:0]     sw_clear,
  // Flags and wake
  output logic      [eid_pkg::NUM_LINES-1:0]     irq_pending,
  output logic                                   wake_req
);
  import eid_pkg::*;

  // Each pin runs through its own detector: three-stage sampler, edge
  // compare and a sticky flag. A pin pulse shorter than two clock cycles
  // may be missed, since a change counts only once two stages agree.
  // Wake-up relies on the sampling clock staying alive in power-down;
  // a fully stopped clock needs a pad-level latch outside this block.

  // Elaboration checks: the wiring below serves exactly these lines
  if (LINE_FOUR + 1 != NUM_LINES) begin : g_bad_index
    $error("eid_top: line indices do not cover all lines");
  end
  if (SEL_ZERO_BIT >= CTRL_W) begin : g_bad_sel_zero
    $error("eid_top: first edge select lies outside the control image");
  end
  if (SEL_ONE_BIT >= CTRL_W) begin : g_bad_sel_one
    $error("eid_top: second edge select lies outside the control image");
  end
  if (SYNC_STAGES != 3) begin : g_bad_sync
    $error("eid_top: the pin samplers need three stages");
  end

  // Pins as they arrive from the pads, one wire per line
  logic                 pin_zero;
  logic                 pin_one;
  logic                 pin_two;
  logic                 pin_three;
  logic                 pin_four;

  // Edge mode per line: high accepts rising and falling edges
  logic                 mode_zero;
  logic                 mode_one;
  logic                 mode_two;
  logic                 mode_three;
  logic                 mode_four;

  // Flag clears per line, from the core or from software
  logic                 clr_zero;
  logic                 clr_one;
  logic                 clr_two;
  logic                 clr_three;
  logic                 clr_four;

  // Sticky flags as held inside each line detector
  logic                 pend_zero;
  logic                 pend_one;
  logic                 pend_two;
  logic                 pend_three;
  logic                 pend_four;

  // One-cycle strobes for a qualifying edge on each line
  logic                 seen_zero;
  logic                 seen_one;
  logic                 seen_two;
  logic                 seen_three;
  logic                 seen_four;

  // Gathered vectors and the output registers
  logic [NUM_LINES-1:0] pend;
  logic [NUM_LINES-1:0] wake_src;
  logic                 wake_hit;
  logic [NUM_LINES-1:0] pend_q;
  logic                 wake_q;

  // Pin fan-out, each straight into its sampler
  assign pin_zero  = ext_irq_line_zero;  // see R12
  assign pin_one   = ext_irq_line_one;   // see R12
  assign pin_two   = ext_irq_line_two;   // see R12
  assign pin_three = ext_irq_line_three; // see R12
  assign pin_four  = ext_irq_line_four;  // see R12

  // Edge mode per line: only zero and one are selectable
  assign mode_zero  = !timer_irq_control_reg[SEL_ZERO_BIT]; // see R1 see R2
  assign mode_one   = !timer_irq_control_reg[SEL_ONE_BIT];  // see R3 see R4
  assign mode_two   = 1'h0;                                 // see R5
  assign mode_three = 1'h0;                                 // see R6
  assign mode_four  = 1'h0;                                 // see R10

  // Acknowledge or software write clears the flag
  assign clr_zero  = irq_ack[LINE_ZERO]  | sw_clear[LINE_ZERO];  // see R11
  assign clr_one   = irq_ack[LINE_ONE]   | sw_clear[LINE_ONE];   // see R11
  assign clr_two   = irq_ack[LINE_TWO]   | sw_clear[LINE_TWO];   // see R11
  assign clr_three = irq_ack[LINE_THREE] | sw_clear[LINE_THREE]; // see R11
  assign clr_four  = irq_ack[LINE_FOUR]  | sw_clear[LINE_FOUR];  // see R11

  // Line zero: edge mode follows the first select bit,
  // the flag clears on acknowledge or software write,
  // and it never requests a wake
  eid_line #(
    .STAGES    (SYNC_STAGES)
  ) u_line_zero (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin       (pin_zero),    // see R12
    .any_edge  (mode_zero),
    .clear     (clr_zero),
    .pending   (pend_zero),   // see R11
    .edge_seen (seen_zero)
  );

  // Line one: edge mode follows the second select bit;
  // any accepted edge, falling or rising, may wake
  // the device while it sits in power-down
  eid_line #(
    .STAGES    (SYNC_STAGES)
  ) u_line_one (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin       (pin_one),     // see R12
    .any_edge  (mode_one),
    .clear     (clr_one),
    .pending   (pend_one),    // see R11
    .edge_seen (seen_one)
  );

  // Line two: falling edges only, with no select;
  // a falling edge may wake the device
  // while it sits in power-down
  eid_line #(
    .STAGES    (SYNC_STAGES)
  ) u_line_two (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin       (pin_two),     // see R12
    .any_edge  (mode_two),
    .clear     (clr_two),
    .pending   (pend_two),    // see R11
    .edge_seen (seen_two)
  );

  // Line three: falling edges only, with no select;
  // a falling edge may wake the device
  // while it sits in power-down
  eid_line #(
    .STAGES    (SYNC_STAGES)
  ) u_line_three (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin       (pin_three),   // see R12
    .any_edge  (mode_three),
    .clear     (clr_three),
    .pending   (pend_three),  // see R11
    .edge_seen (seen_three)
  );

  // Line four: falling edges only, with no select;
  // a falling edge may wake the device
  // while it sits in power-down
  eid_line #(
    .STAGES    (SYNC_STAGES)
  ) u_line_four (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin       (pin_four),    // see R12
    .any_edge  (mode_four),
    .clear     (clr_four),
    .pending   (pend_four),   // see R11
    .edge_seen (seen_four)
  );

  // Flags gathered in line order
  assign pend = {pend_four, pend_three, pend_two, pend_one, pend_zero};

  // Wake sources: lines one to four; line zero is left out on purpose
  assign wake_src = {seen_four, seen_three, seen_two, seen_one, 1'h0}; // see R7 see R8 see R9
  assign wake_hit = power_down && (|wake_src);                          // see R7 see R8 see R9

  // Registered flags for the core
  always_ff @(posedge clk) begin
    if (!rst_n) pend_q <= {NUM_LINES{FLAG_RESET}};
    else        pend_q <= pend;
  end

  // Wake request, one cycle per accepted edge on lines one to four in power-down; the sampler
  // clock is assumed to stay alive while the device sleeps
  always_ff @(posedge clk) begin
    if (!rst_n) wake_q <= FLAG_RESET;
    else        wake_q <= wake_hit;
  end

  // Outputs straight from the registers
  assign irq_pending = pend_q;
  assign wake_req    = wake_q;
endmodule : eid_top

// *** eid_pkg.sv ***
// Package: constants for the external interrupt edge detector
package eid_pkg;
  localparam int unsigned NUM_LINES    = 5;
  localparam int unsigned SYNC_STAGES  = 3;
  // Line indices
  localparam int unsigned LINE_ZERO    = 0;
  localparam int unsigned LINE_ONE     = 1;
  localparam int unsigned LINE_TWO     = 2;
  localparam int unsigned LINE_THREE   = 3;
  localparam int unsigned LINE_FOUR    = 4;
  // Bit positions of the edge selects inside the control register image
  localparam int unsigned CTRL_W       = 8;
  localparam int unsigned SEL_ZERO_BIT = 0;
  localparam int unsigned SEL_ONE_BIT  = 2;
  // Reset values
  localparam logic        PIN_IDLE     = 1'h1;
  localparam logic        FLAG_RESET   = 1'h0;
  // Line state machine codes
  typedef enum logic [1:0] {
    EID_ST_IDLE = 2'h1,
    EID_ST_PEND = 2'h2
  } eid_state_e;
endpackage : eid_pkg

// *** eid_line.sv ***
// Module: one interrupt line, synchroniser, edge detector and pending flag
`timescale 1ns/1ns
module eid_line
  import eid_pkg::*;
#(
  parameter int unsigned STAGES = eid_pkg::SYNC_STAGES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pin and mode
  input  wire logic pin,
  input  wire logic any_edge,
  // Flag control
  input  wire logic clear,
  output logic      pending,
  output logic      edge_seen
);
  import eid_pkg::*;

  initial begin
    if (STAGES != 3) $error("eid_line: STAGES must be 3");
  end

  logic [STAGES-1:0] sync_q;
  logic              level_q;
  eid_state_e        state_q;
  eid_state_e        state_d;

  // Agreement of last two stages gives a stable level; stage 0 feeds only stage 1
  wire stable    = (sync_q[1] == sync_q[2]);
  wire new_level = sync_q[2];
  wire fall      = stable && level_q && !new_level;
  wire rise      = stable && !level_q && new_level;
  wire hit       = fall || (any_edge && rise);

  // Pin synchroniser and last accepted level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_q  <= {STAGES{PIN_IDLE}};
      level_q <= PIN_IDLE;
    end else begin
      sync_q  <= {sync_q[STAGES-2:0], pin};
      if (stable) level_q <= new_level;
    end
  end

  // Pending flag; a new edge wins over a clear in the same cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      EID_ST_IDLE: if (hit) state_d = EID_ST_PEND;
      EID_ST_PEND: if (clear && !hit) state_d = EID_ST_IDLE;
      default:     state_d = EID_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) state_q <= EID_ST_IDLE;
    else        state_q <= state_d;
  end

  assign pending   = (state_q == EID_ST_PEND);
  assign edge_seen = hit;
endmodule : eid_line

// *** eid_top_asserts.sv ***
// Checker: port assertions for the edge detector
`timescale 1ns/1ns
module eid_top_asserts
  import eid_pkg::*;
(
  // Watched ports
  input wire logic clk, rst_n, power_down, wake_req,
  input wire logic ext_irq_line_zero, ext_irq_line_one, ext_irq_line_two,
  input wire logic ext_irq_line_three, ext_irq_line_four,
  input wire logic [eid_pkg::CTRL_W-1:0] timer_irq_control_reg,
  input wire logic [eid_pkg::NUM_LINES-1:0] irq_ack, sw_clear, irq_pending
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Any clear request on a line
  wire logic [4:0] clr = irq_ack | sw_clear;
  a_two_fall_sets: assert property ($fell(ext_irq_line_two) |-> ##[3:6] irq_pending[2])
    else $error("fall two missed");
  a_two_no_rise: assert property ($rose(irq_pending[2]) |-> !$past(ext_irq_line_two, 3))
    else $error("rise two flagged");
  a_zero_fall_only: assert property ($rose(irq_pending[0]) && timer_irq_control_reg[0] |-> !$past(ext_irq_line_zero, 3))
    else $error("rise zero flagged");
  a_zero_any_edge: assert property (!timer_irq_control_reg[0] && $rose(ext_irq_line_zero) |-> ##[3:6] irq_pending[0])
    else $error("rise zero missed");
  a_one_fall_only: assert property ($rose(irq_pending[1]) && timer_irq_control_reg[2] |-> !$past(ext_irq_line_one, 3))
    else $error("rise one flagged");
  a_one_any_edge: assert property (!timer_irq_control_reg[2] && $rose(ext_irq_line_one) |-> ##[3:6] irq_pending[1])
    else $error("rise one missed");
  a_flag_holds: assert property ((~irq_pending & $past(irq_pending) & ~($past(clr) | $past(clr, 2) | $past(clr, 3))) == 5'h00)
    else $error("flag dropped");
  a_wake_two: assert property (power_down && $fell(ext_irq_line_two) |-> ##[3:6] wake_req)
    else $error("wake missed");
endmodule : eid_top_asserts

// *** eid_src.sv ***
// Partner: outside sources driving the interrupt pins
`timescale 1ns/1ns
module eid_src (
  // Clock and requested levels
  input  wire logic       clk,
  input  wire logic [4:0] lvl,
  // Pins, idle high
  output logic      [4:0] pin
);
  // Pins move a fixed delay after the edge
  initial pin = 5'h1F;
  always @(posedge clk) pin <= #10 lvl;
endmodule : eid_src

// *** eid_top_test.sv ***
// Testbench: edge detector scenarios
`timescale 1ns/1ns
module eid_top_test;
  import eid_pkg::*;
  logic clk = 0, rst_n = 0, pd = 0, wake, w;
  logic [7:0] ctl = 8'h05;
  logic [4:0] lvl = 5'h1F, ack = 5'h00, swc = 5'h00, pin, pend;
  int miscompares = 0, checked = 0;
  initial forever #50 clk = ~clk;
  eid_src i_src (.clk(clk), .lvl(lvl), .pin(pin));
  eid_top i_dut (.clk(clk), .rst_n(rst_n), .ext_irq_line_zero(pin[0]),
    .ext_irq_line_one(pin[1]), .ext_irq_line_two(pin[2]), .ext_irq_line_three(pin[3]),
    .ext_irq_line_four(pin[4]), .timer_irq_control_reg(ctl), .power_down(pd),
    .irq_ack(ack), .sw_clear(swc), .irq_pending(pend), .wake_req(wake));
  task automatic chk(input string nm, input logic [4:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : cyc
  // Move one pin, hold it, check the flag, acknowledge it
  task automatic drive(input int k, input logic v, input logic [4:0] e);
    lvl[k] = v;
    cyc(20);
    chk("pend", pend, e);
    ack[k] = 1;
    cyc(1);
    ack[k] = 0;
    cyc(5);
    chk("pend", pend, 5'h00);
  endtask : drive
  task automatic t_fall_only;
    ctl = 8'h05;
    for (int k = 0; k < 5; k++) begin
      drive(k, 0, 5'h01 << k);
      drive(k, 1, 5'h00);
    end
  endtask : t_fall_only
  task automatic t_any_edge;
    ctl = 8'h00;
    for (int k = 0; k < 2; k++) begin
      drive(k, 0, 5'h01 << k);
      drive(k, 1, 5'h01 << k);
    end
  endtask : t_any_edge
  task automatic t_wake;
    ctl = 8'h05;
    pd = 1;
    for (int k = 0; k < 5; k++) begin
      lvl[k] = 0;
      w = 0;
      repeat (10) begin
        cyc(1);
        w |= wake;
      end
      chk("wake", w, (k > 0) ? 5'h01 : 5'h00);
      lvl[k] = 1;
      swc[k] = 1;
      cyc(1);
      swc[k] = 0;
      cyc(8);
    end
    pd = 0;
    chk("pend", pend, 5'h00);
  endtask : t_wake
  task automatic finish_test;
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    cyc(12);
    rst_n = 1;
    t_fall_only();
    t_any_edge();
    t_wake();
    finish_test();
  end
endmodule : eid_top_test
bind eid_top eid_top_asserts i_chk (.clk(clk), .rst_n(rst_n), .power_down(power_down),
  .wake_req(wake_req), .ext_irq_line_zero(ext_irq_line_zero),
  .ext_irq_line_one(ext_irq_line_one), .ext_irq_line_two(ext_irq_line_two),
  .ext_irq_line_three(ext_irq_line_three), .ext_irq_line_four(ext_irq_line_four),
  .timer_irq_control_reg(timer_irq_control_reg), .irq_ack(irq_ack),
  .sw_clear(sw_clear), .irq_pending(irq_pending));
